// >>> rtl/pec_pkg.sv
package pec_pkg;

	localparam int NUM_CNT = 16;
	localparam int CNT_W = 32;
	localparam int ADDR_W = 9;
	// identifier bits 14:12 give the width of the value field
	localparam logic [2:0] WIDTH_CODE = 3'h2;
	localparam logic VENDOR_BIT = 1'b0;
	localparam logic [8:0] HDR_END = 9'h004;
	localparam logic [8:0] LAST_ADDR = 9'h1ff;
	localparam logic [2:0] OFF_ID_LO = 3'h0;
	localparam logic [2:0] OFF_ID_HI = 3'h1;
	localparam logic [2:0] OFF_V0 = 3'h2;
	localparam logic [2:0] OFF_V1 = 3'h3;
	localparam logic [2:0] OFF_V2 = 3'h4;
	localparam logic [2:0] OFF_LAST = 3'h5;
	localparam logic [4:0] SLOT_END = 5'h10;

	// event index order is also the order of entries in the page
	localparam int EV_INTERFACE_CRC_FLAG = 0;
	localparam int EV_DATA = 1;
	localparam int EV_TX_DATA = 2;
	localparam int EV_RX_DATA = 3;
	localparam int EV_NDATA = 4;
	localparam int EV_TX_NDATA = 5;
	localparam int EV_RX_NDATA = 6;
	localparam int EV_RETRY = 7;
	localparam int EV_LINK_DROP = 8;
	localparam int EV_SIG = 9;
	localparam int EV_RX_CRC = 10;
	localparam int EV_RX_OTHER = 11;
	localparam int EV_RXD_CRC = 12;
	localparam int EV_RXD_OTHER = 13;
	localparam int EV_RXN_CRC = 14;
	localparam int EV_RXN_OTHER = 15;

	localparam logic [11:0] CNT_CODE [NUM_CNT] = '{
		12'h001, 12'h002, 12'h003, 12'h004, 12'h005, 12'h006, 12'h007, 12'h008,
		12'h009, 12'h00a, 12'h00b, 12'h00d, 12'h00f, 12'h010, 12'h012, 12'h013
	};

	// counters fed by an error response ending status
	localparam logic [NUM_CNT-1:0] RERR_MASK = 16'hfc7e;

	typedef enum logic [1:0] {PEC_IDLE, PEC_FILL, PEC_READY} pec_state_t;

	function automatic logic [15:0] pec_make_id(input logic [11:0] code);
		return {VENDOR_BIT, WIDTH_CODE, code};
	endfunction

endpackage

// >>> rtl/pec_sat_counter.sv
`timescale 1ns/1ps
`default_nettype none
module pec_sat_counter #(
	parameter int W = 32
) (
	input wire logic sys_clk,
	input wire logic rst_b,
	input wire logic inc,
	input wire logic clr,
	output logic [W-1:0] value
);

	localparam logic [W-1:0] MAX = '1;
	localparam logic [W-1:0] ONE = W'(1);

	// only power-on reset reaches here; link and software resets do not
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			value <= '0;
		end else if (clr) begin
			// an event in the clearing cycle is kept
			value <= inc ? ONE : '0;
		end else if (inc && value != MAX) begin
			value <= value + ONE;
		end
	end

	cnt_step_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
		inc && !clr && value != MAX |=> value == $past(value) + ONE)
		else $error("counter did not step by one");

	cnt_sat_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
		value == MAX && !clr |=> value == MAX)
		else $error("counter wrapped past maximum");

	cnt_clr_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
		clr |=> value == (W'($past(inc))))
		else $error("counter clear lost or wrong");

endmodule
`default_nettype wire

// >>> rtl/pec_log_mem.sv
`timescale 1ns/1ps
`default_nettype none
module pec_log_mem (
	input wire logic sys_clk,
	input wire logic rst_b,
	input wire logic wrEn,
	input wire logic [8:0] wrAddr,
	input wire logic [7:0] wrData,
	input wire logic rdEn,
	input wire logic [8:0] rdAddr,
	output logic [7:0] rdData
);

	logic [7:0] mem [512];

	always_ff @(posedge sys_clk) begin
		if (wrEn) begin
			mem[wrAddr] <= wrData;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			rdData <= 8'h00;
		end else if (rdEn) begin
			rdData <= mem[rdAddr];
		end
	end

endmodule
`default_nettype wire

// >>> rtl/pec_event_log.sv
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - power-on reset clears the counters; they survive link and software reset.
// - a BIST activate pulse clears every counter.
// - log read with clear flag returns current values, then clears counters.
// - each log entry is a 16-bit identifier followed by its value.
// - identifier bits 14:12 code the width; all counters here are 32 bits.
// - bit 15 marks vendor counters; none built, bit 15 kept zero.
// - unused entry space reads zero; a zero identifier ends the list.
// - mandatory counters 001h and 00Ah are built; unbuilt ones never appear.
// - zero means no event seen; entries may be in any order.
// - 001h counts commands ending with error status and interface crc flag.
// - 002h-004h count data frames answered with error response, by direction.
// - 005h-007h count non-data frames answered with error response, retries included.
// - 008h counts device-sent non-data frames retried after an error response.
// - 009h counts each fall from link ready to link not ready.
// - 00Ah counts reset-signature frames acknowledged by the host.
// - 00Bh and 00Dh count received error responses, crc and other causes.
// - 00Fh, 010h, 012h, 013h split received error responses four ways.
// - frames ended by a sync escape are not counted as error endings.
// - port-multiplier counters C00h-C02h are optional and not built.
// - feature support is reported for identify word 76 bit 10.
// - counters saturate at all ones instead of wrapping.
// - the log is one 512-byte page; entries start at byte 4.
// - the last byte makes the sum of all 512 bytes zero.
module pec_event_log (
	input wire logic sys_clk,
	input wire logic rst_b,
	input wire logic cmdDoneStrobe,
	input wire logic cmdStatusErr,
	input wire logic interface_crc_flag,
	input wire logic txDataRerr,
	input wire logic txNonDataRerr,
	input wire logic txNonDataRetry,
	input wire logic rxRerrStrobe,
	input wire logic rxRerrIsData,
	input wire logic rxRerrIsCrc,
	input wire logic fisSyncEscape,
	input wire logic link_ready_state,
	input wire logic sigFisAcked,
	input wire logic bistActivate,
	input wire logic logReadReq,
	input wire logic logReadClearFlag,
	input wire logic logRdEn,
	input wire logic [8:0] logRdAddr,
	output logic logReady,
	output logic logRdValid,
	output logic [7:0] logRdData,
	output logic featureSupported
);

	localparam logic [31:0] CNT_MAX = '1;
	// last value of the build cycle count: 512 byte writes, one per cycle
	localparam logic [9:0] BUILD_LAST = 10'h1ff;

	pec_pkg::pec_state_t state;
	logic [pec_pkg::NUM_CNT-1:0] evt;
	logic [pec_pkg::CNT_W-1:0] cnt [pec_pkg::NUM_CNT];
	logic [pec_pkg::CNT_W-1:0] snap [pec_pkg::NUM_CNT];
	logic [pec_pkg::CNT_W-1:0] snapSel;
	logic [15:0] idSel;
	logic linkReadyPrev;
	logic accept;
	logic clrAll;
	logic [8:0] fillAddr;
	logic [4:0] slot;
	logic [2:0] off;
	logic [7:0] csum;
	logic [7:0] fillByte;
	logic fillWr;
	logic inEntries;
	logic [7:0] pageSum;
	logic [9:0] buildCyc;

	// a new page is built only when no build is running
	assign accept = logReadReq && state != pec_pkg::PEC_FILL;
	// clearing in the snapshot cycle returns the old values and loses no event
	assign clrAll = bistActivate || (accept && logReadClearFlag);
	assign fillWr = state == pec_pkg::PEC_FILL;
	assign inEntries = fillAddr >= pec_pkg::HDR_END && slot != pec_pkg::SLOT_END;

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			linkReadyPrev <= 1'b0;
		end else begin
			linkReadyPrev <= link_ready_state;
		end
	end

	always_comb begin
		logic rxD;
		logic rxN;
		logic gate;
		gate = !fisSyncEscape;
		rxD = rxRerrStrobe && rxRerrIsData;
		rxN = rxRerrStrobe && !rxRerrIsData;
		evt = '0;
		evt[pec_pkg::EV_INTERFACE_CRC_FLAG] = cmdDoneStrobe && cmdStatusErr && interface_crc_flag;
		evt[pec_pkg::EV_DATA] = gate && (txDataRerr || rxD);
		evt[pec_pkg::EV_TX_DATA] = gate && txDataRerr;
		evt[pec_pkg::EV_RX_DATA] = gate && rxD;
		evt[pec_pkg::EV_NDATA] = gate && (txNonDataRerr || rxN);
		evt[pec_pkg::EV_TX_NDATA] = gate && txNonDataRerr;
		evt[pec_pkg::EV_RX_NDATA] = gate && rxN;
		evt[pec_pkg::EV_RETRY] = txNonDataRetry;
		evt[pec_pkg::EV_LINK_DROP] = linkReadyPrev && !link_ready_state;
		evt[pec_pkg::EV_SIG] = sigFisAcked;
		evt[pec_pkg::EV_RX_CRC] = gate && rxRerrStrobe && rxRerrIsCrc;
		evt[pec_pkg::EV_RX_OTHER] = gate && rxRerrStrobe && !rxRerrIsCrc;
		evt[pec_pkg::EV_RXD_CRC] = gate && rxD && rxRerrIsCrc;
		evt[pec_pkg::EV_RXD_OTHER] = gate && rxD && !rxRerrIsCrc;
		evt[pec_pkg::EV_RXN_CRC] = gate && rxN && rxRerrIsCrc;
		evt[pec_pkg::EV_RXN_OTHER] = gate && rxN && !rxRerrIsCrc;
	end

	// port-multiplier counters are not built and so never enter the page
	for (genvar i = 0; i < pec_pkg::NUM_CNT; i++) begin : gCnt
		pec_sat_counter #(
			.W(pec_pkg::CNT_W)
		) uCnt (
			.sys_clk(sys_clk),
			.rst_b(rst_b),
			.inc(evt[i]),
			.clr(clrAll),
			.value(cnt[i])
		);
	end

	// snapshot keeps each entry whole while counters move on underneath
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			for (int i = 0; i < pec_pkg::NUM_CNT; i++) begin
				snap[i] <= '0;
			end
		end else if (accept) begin
			for (int i = 0; i < pec_pkg::NUM_CNT; i++) begin
				snap[i] <= cnt[i];
			end
		end
	end

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			state <= pec_pkg::PEC_IDLE;
			logReady <= 1'b0;
		end else begin
			case (state)
				pec_pkg::PEC_IDLE, pec_pkg::PEC_READY: begin
					if (accept) begin
						state <= pec_pkg::PEC_FILL;
						logReady <= 1'b0;
					end
				end
				pec_pkg::PEC_FILL: begin
					if (fillAddr == pec_pkg::LAST_ADDR) begin
						state <= pec_pkg::PEC_READY;
						logReady <= 1'b1;
					end
				end
				default: begin
					state <= pec_pkg::PEC_IDLE;
					logReady <= 1'b0;
				end
			endcase
		end
	end

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			fillAddr <= '0;
			slot <= '0;
			off <= '0;
			csum <= '0;
		end else if (accept) begin
			fillAddr <= '0;
			slot <= '0;
			off <= '0;
			csum <= '0;
		end else if (fillWr) begin
			fillAddr <= fillAddr + 9'h001;
			csum <= csum + fillByte;
			if (inEntries) begin
				if (off == pec_pkg::OFF_LAST) begin
					off <= '0;
					slot <= slot + 5'h01;
				end else begin
					off <= off + 3'h1;
				end
			end
		end
	end

	assign snapSel = snap[slot[3:0]];
	assign idSel = pec_pkg::pec_make_id(pec_pkg::CNT_CODE[slot[3:0]]);

	// identifier and value are stored least significant byte first
	always_comb begin
		fillByte = 8'h00;
		if (fillAddr == pec_pkg::LAST_ADDR) begin
			fillByte = 8'h00 - csum;
		end else if (inEntries) begin
			case (off)
				pec_pkg::OFF_ID_LO: begin
					fillByte = idSel[7:0];
				end
				pec_pkg::OFF_ID_HI: begin
					fillByte = idSel[15:8];
				end
				pec_pkg::OFF_V0: begin
					fillByte = snapSel[7:0];
				end
				pec_pkg::OFF_V1: begin
					fillByte = snapSel[15:8];
				end
				pec_pkg::OFF_V2: begin
					fillByte = snapSel[23:16];
				end
				default: begin
					fillByte = snapSel[31:24];
				end
			endcase
		end
	end

	pec_log_mem uMem (
		.sys_clk(sys_clk),
		.rst_b(rst_b),
		.wrEn(fillWr),
		.wrAddr(fillAddr),
		.wrData(fillByte),
		.rdEn(logRdEn && logReady),
		.rdAddr(logRdAddr),
		.rdData(logRdData)
	);

	// reads while a page is being built are ignored
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			logRdValid <= 1'b0;
		end else begin
			logRdValid <= logRdEn && logReady;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			featureSupported <= 1'b0;
		end else begin
			featureSupported <= 1'b1;
		end
	end

	// helper: running sum of every byte written, checksum included
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			pageSum <= '0;
		end else if (accept) begin
			pageSum <= '0;
		end else if (fillWr) begin
			pageSum <= pageSum + fillByte;
		end
	end

	// helper: cycles spent in a build, kept apart from the write address so a stuck
	// address is still caught by the length checks below
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			buildCyc <= '0;
		end else if (accept) begin
			buildCyc <= '0;
		end else if (fillWr) begin
			buildCyc <= buildCyc + 10'h001;
		end
	end

	page_sum_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
		fillWr && fillAddr == pec_pkg::LAST_ADDR |=> pageSum == 8'h00)
		else $error("log page does not sum to zero");

	fill_start_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
		accept |=> fillWr && !logReady && buildCyc == 10'h000)
		else $error("page build did not start after request");

	fill_time_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
		fillWr |-> !logReady && buildCyc <= BUILD_LAST)
		else $error("page build ran past 512 cycles");

	fill_end_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
		fillWr && buildCyc == BUILD_LAST |=> logReady && !fillWr)
		else $error("page not ready after 512 cycles");

	rd_valid_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
		logRdEn && logReady |=> logRdValid)
		else $error("read of ready page not answered");

	escape_gate_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
		fisSyncEscape |-> (evt & pec_pkg::RERR_MASK) == '0)
		else $error("sync escape counted as error ending");

	link_drop_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
		$fell(link_ready_state) && !clrAll && cnt[pec_pkg::EV_LINK_DROP] != CNT_MAX
		|=> cnt[pec_pkg::EV_LINK_DROP] == $past(cnt[pec_pkg::EV_LINK_DROP]) + 32'h1)
		else $error("link drop not counted");

	read_clear_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
		accept && logReadClearFlag |=> snap[pec_pkg::EV_SIG] == $past(cnt[pec_pkg::EV_SIG])
		&& cnt[pec_pkg::EV_SIG] <= 32'h1)
		else $error("read with clear did not return then clear");

	support_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
		$past(rst_b) |-> featureSupported)
		else $error("feature support bit not reported");

endmodule
`default_nettype wire

// >>> testbench/pec_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module pec_host_model (
	input wire logic sys_clk,
	output logic bistActivate,
	output logic logReadReq,
	output logic logReadClearFlag,
	output logic logRdEn,
	output logic [8:0] logRdAddr
);
	initial begin
		bistActivate = 1'b0;
		logReadReq = 1'b0;
		logReadClearFlag = 1'b0;
		logRdEn = 1'b0;
		logRdAddr = 9'h000;
	end

	// released qualifiers show the inverse so a stale value is never trusted
	task automatic page_req(input logic clr);
		@(negedge sys_clk);
		logReadReq = 1'b1;
		logReadClearFlag = clr;
		@(negedge sys_clk);
		logReadReq = 1'b0;
		logReadClearFlag = ~clr;
	endtask

	task automatic bist_pulse();
		@(negedge sys_clk);
		bistActivate = 1'b1;
		@(negedge sys_clk);
		bistActivate = 1'b0;
	endtask

	task automatic read_range(input int first, input int count);
		for (int a = first; a < first + count; a++) begin
			@(negedge sys_clk);
			logRdEn = 1'b1;
			logRdAddr = a[8:0];
		end
		@(negedge sys_clk);
		logRdEn = 1'b0;
		logRdAddr = ~logRdAddr;
	endtask
endmodule
`default_nettype wire

// >>> testbench/test_pec_event_log.sv
`timescale 1ns/1ps
`default_nettype none
module test_pec_event_log;
	logic sys_clk = 1'b0;
	logic rst_b = 1'b0;
	logic [11:0] ev = 12'h000;
	logic bistActivate, logReadReq, logReadClearFlag, logRdEn;
	logic [8:0] logRdAddr;
	logic logReady, logRdValid, featureSupported;
	logic [7:0] logRdData;
	logic [31:0] cnt [16];
	logic [7:0] expQ [$];
	logic evOn = 1'b0;
	logic prevLink = 1'b0;
	int seed = 32'h42ce59c2;
	int err_total = 0;
	int n_tests = 0;
	int cyc = 0;

	always #2.5 sys_clk = ~sys_clk;

	pec_host_model host (.sys_clk(sys_clk), .bistActivate(bistActivate),
		.logReadReq(logReadReq), .logReadClearFlag(logReadClearFlag),
		.logRdEn(logRdEn), .logRdAddr(logRdAddr));

	pec_event_log dut (.sys_clk(sys_clk), .rst_b(rst_b), .cmdDoneStrobe(ev[0]),
		.cmdStatusErr(ev[1]), .interface_crc_flag(ev[2]), .txDataRerr(ev[3]),
		.txNonDataRerr(ev[4]), .txNonDataRetry(ev[5]), .rxRerrStrobe(ev[6]),
		.rxRerrIsData(ev[7]), .rxRerrIsCrc(ev[8]), .fisSyncEscape(ev[9]),
		.link_ready_state(ev[10]), .sigFisAcked(ev[11]), .bistActivate(bistActivate),
		.logReadReq(logReadReq), .logReadClearFlag(logReadClearFlag), .logRdEn(logRdEn),
		.logRdAddr(logRdAddr), .logReady(logReady), .logRdValid(logRdValid),
		.logRdData(logRdData), .featureSupported(featureSupported));

	task automatic final_report();
		$display("comparisons %0d mismatches %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask

	task automatic check(input string name, input logic [31:0] exp, input logic [31:0] seen);
		n_tests++;
		if (seen !== exp) begin
			err_total++;
			$display("CHECK FAILED %s expected %0h seen %0h", name, exp, seen);
		end
	endtask

	// expected steps for one edge, index order follows the page entry order
	function automatic logic [15:0] incs(input logic [11:0] e, input logic p);
		logic td, tn, rx, d, c;
		td = e[3] & !e[9];
		tn = e[4] & !e[9];
		rx = e[6] & !e[9];
		d = e[7];
		c = e[8];
		return {rx & !d & !c, rx & !d & c, rx & d & !c, rx & d & c,
			rx & !c, rx & c, e[11], p & !e[10], e[5],
			rx & !d, tn, tn | (rx & !d), rx & d, td, td | (rx & d),
			e[0] & e[1] & e[2]};
	endfunction

	always @(negedge sys_clk) begin
		logic [15:0] inc;
		if (evOn) ev = 12'($random(seed));
		else ev = ev & 12'h400;
		inc = incs(ev, prevLink);
		prevLink = ev[10];
		for (int i = 0; i < 16; i++) begin
			if (inc[i] && cnt[i] != 32'hffffffff) cnt[i] = cnt[i] + 32'h1;
		end
	end

	always @(negedge sys_clk) begin
		if (logRdValid === 1'b1) begin
			if (expQ.size() == 0) check("logRdValid", 32'h0, 32'h1);
			else check("logRdData", expQ.pop_front(), logRdData);
		end
	end

	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 20000) begin
			err_total++;
			final_report();
		end
	end

	// events keep running during the build, so they must land in counters, not the page
	task automatic read_page(input logic clr);
		logic [31:0] snap [16];
		logic [15:0] id;
		logic [7:0] b, sum;
		int k, o, i;
		evOn = 1'b0;
		@(negedge sys_clk);
		snap = cnt;
		host.page_req(clr);
		if (clr) foreach (cnt[j]) cnt[j] = 32'h0;
		evOn = 1'b1;
		@(negedge sys_clk);
		check("logReady", 32'h0, logReady);
		host.read_range(4, 1);
		host.page_req(1'b1);
		for (i = 0; i < 1200 && logReady !== 1'b1; i++) @(negedge sys_clk);
		check("logReady", 32'h1, logReady);
		sum = 8'h00;
		for (i = 0; i < 511; i++) begin
			b = 8'h00;
			if (i >= 4 && i < 100) begin
				k = (i - 4) / 6;
				o = (i - 4) % 6;
				id = {1'b0, 3'h2, pec_pkg::CNT_CODE[k]};
				b = (o < 2) ? id[8*o +: 8] : snap[k][8*(o-2) +: 8];
			end
			expQ.push_back(b);
			sum = sum + b;
		end
		expQ.push_back(8'h00 - sum);
		host.read_range(0, 512);
		repeat (3) @(negedge sys_clk);
		check("notes left", 32'h0, expQ.size());
	endtask

	initial begin
		foreach (cnt[j]) cnt[j] = 32'h0;
		repeat (16) @(posedge sys_clk);
		@(negedge sys_clk);
		rst_b = 1'b1;
		@(negedge sys_clk);
		check("featureSupported", 32'h1, featureSupported);
		check("logReady", 32'h0, logReady);
		evOn = 1'b1;
		repeat (300) @(negedge sys_clk);
		read_page(1'b0);
		repeat (200) @(negedge sys_clk);
		read_page(1'b1);
		repeat (100) @(negedge sys_clk);
		read_page(1'b0);
		evOn = 1'b0;
		@(negedge sys_clk);
		host.bist_pulse();
		foreach (cnt[j]) cnt[j] = 32'h0;
		read_page(1'b0);
		evOn = 1'b0;
		@(negedge sys_clk);
		rst_b = 1'b0;
		repeat (3) @(negedge sys_clk);
		check("featureSupported", 32'h0, featureSupported);
		foreach (cnt[j]) cnt[j] = 32'h0;
		prevLink = 1'b0;
		rst_b = 1'b1;
		read_page(1'b0);
		final_report();
	end
endmodule
`default_nettype wire
